/* File: hdl/acc_defs.vh */
// Constants for the converter calibration control block
// Assumes APB with 32-bit data; registers at word index times four
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH
// Register indexes (byte address is index times four)
`define ACC_IDX_MODE      8'hb0
`define ACC_IDX_STATUS    8'hb1
`define ACC_IDX_IMASK     8'hb2
`define ACC_IDX_GAIN_L    8'hb4
`define ACC_IDX_GAIN_M    8'hb5
`define ACC_IDX_GAIN_H    8'hb6
`define ACC_IDX_OFS_L     8'hba
`define ACC_IDX_OFS_M     8'hbb
`define ACC_IDX_OFS_H     8'hbc
`define ACC_IDX_BUF       8'hbd
`define ACC_IDX_RESULT    8'hbe
// System mode encodings
`define ACC_SM_IDLE       3'h0
`define ACC_SM_CONT       3'h1
`define ACC_SM_INT_OFS    3'h4
`define ACC_SM_INT_GAIN   3'h5
`define ACC_SM_SYS_OFS    3'h6
`define ACC_SM_SYS_GAIN   3'h7
`define ACC_SM_INT_FULL   3'h3
// Field positions
`define ACC_ST_CALC       0
`define ACC_ST_BUSY       1
`define ACC_ST_CONV       2
// Reset values
`define ACC_RST_BUF       8'h00
`define ACC_RST_OFS       24'h000000
`define ACC_RST_GAIN      24'h400000
// Gain factor fixed point: 1.0 = 2^22
`define ACC_GAIN_FRAC     22
`define ACC_FULL_SCALE    24'h3fffff
// Measurement time
`define ACC_MEAS_NS       200
`define ACC_MEAS_CYC      ((`ACC_MEAS_NS + 9) / 10)
`endif

/* File: hdl/acc_cal_ctrl.v */
// Calibration sequencer, coefficient store and input buffer control
// Assumes an APB master on i_mclk and a converter sample on i_raw_sample
`timescale 1ns/10ps
`include "acc_defs.vh"

// Contract
// - System calibration alone also covers internal errors.
// - Offset calibration stores measured deviation; later conversions subtract it.
// - Gain calibration uses one full-scale measurement plus stored offset.
// - Results are offset-corrected first, then multiplied by gain factor.
// - Writing a calibration code into system mode starts that sequence.
// - Busy flag reads one for the whole calibration.
// - On completion: mode idle, busy clear, complete set, interrupt.
// - On completion the result is written to its coefficient registers.
// - Internal offset, gain, and full (offset then gain) modes.
// - Internal offset calibration ties both inputs to analog ground.
// - Internal gain calibration applies reference over amplifier gain.
// - Offset and gain coefficients are 24 bits, software readable/writable.
// - Offset coefficient is two's complement over high, middle, low bytes.
// - Gain coefficient is 24-bit fixed point in its own registers.
// - Offset middle byte bits 15:8, low byte 7:0, reset zero.
module acc_cal_ctrl (
	input  wire        i_mclk,
	input  wire        i_rst_b,
	input  wire        i_psel,
	input  wire        i_penable,
	input  wire        i_pwrite,
	input  wire [11:0] i_paddr,
	input  wire [31:0] i_pwdata,
	output reg  [31:0] o_prdata,
	output reg         o_pready,
	output reg         o_pslverr,
	input  wire [23:0] i_raw_sample,
	input  wire        i_raw_valid,
	output reg         o_ain_to_ground,
	output reg         o_ain_to_fullscale,
	output reg  [23:0] o_corr_sample,
	output reg         o_corr_valid,
	output reg  [7:0]  o_input_buffer_control,
	output reg         o_irq
);

	// ****************************************
	// States
	// ****************************************
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_OFS  = 4'b0010;
	localparam [3:0] ST_GAIN = 4'b0100;
	localparam [3:0] ST_DONE = 4'b1000;

	// ****************************************
	// Timing
	// ****************************************
	localparam [7:0] MEAS_CYC = `ACC_MEAS_CYC;

	reg        rst_s1_ff;
	reg        rst_s2_ff;
	wire       rst_b;
	reg  [3:0] state_ff;
	reg  [3:0] nxt_state;
	reg  [2:0] mode_ff;
	reg        full_ff;
	reg        sys_ff;
	reg  [7:0] meas_cnt_ff;
	reg  [23:0] ofs_ff;
	reg  [23:0] gain_ff;
	reg  [2:0] sts_ff;
	reg  [2:0] mask_ff;
	reg        calc_evt;
	reg        conv_evt;
	reg  [23:0] sample_ff;
	wire       wr_en;
	wire       rd_en;
	wire [7:0] idx;
	wire       busy;
	wire signed [24:0] diff;
	wire signed [49:0] prod;
	wire signed [24:0] fs_span;
	wire [47:0] gain_calc;
	reg  [23:0] gain_new;
	reg  [31:0] nxt_prdata;
	wire [2:0]  sts_set;
	wire [2:0]  sts_clr;
	wire        mode_wr;
	wire        mask_wr;
	wire        sts_wr;
	wire [2:0]  wr_mode;
	wire        wr_sys;

	// ****************************************
	// Reset release
	// ****************************************
	always @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_s2_ff <= rst_s1_ff;
		end
	end
	assign rst_b = rst_s2_ff;

	// ****************************************
	// Bus decode
	// ****************************************
	assign idx   = i_paddr[9:2];
	assign wr_en = i_psel & i_penable & i_pwrite & o_pready;
	assign rd_en = i_psel & ~i_penable & ~i_pwrite;
	assign busy  = ~state_ff[0];

	// ****************************************
	// Write strobes
	// ****************************************
	assign mode_wr = wr_en & (idx == `ACC_IDX_MODE);
	assign mask_wr = wr_en & (idx == `ACC_IDX_IMASK);
	assign sts_wr  = wr_en & (idx == `ACC_IDX_STATUS);
	assign wr_mode = i_pwdata[2:0];
	assign wr_sys  = i_pwdata[2] & i_pwdata[1];

	// ****************************************
	// Decode functions
	// ****************************************

	function known;
		input [7:0] a;
		begin
			case (a)
				`ACC_IDX_MODE, `ACC_IDX_STATUS, `ACC_IDX_IMASK,
				`ACC_IDX_GAIN_L, `ACC_IDX_GAIN_M, `ACC_IDX_GAIN_H,
				`ACC_IDX_OFS_L, `ACC_IDX_OFS_M, `ACC_IDX_OFS_H,
				`ACC_IDX_BUF, `ACC_IDX_RESULT: known = 1'b1;
				default: known = 1'b0;
			endcase
		end
	endfunction

	function is_cal;
		input [2:0] m;
		begin
			is_cal = (m == `ACC_SM_INT_OFS) | (m == `ACC_SM_INT_GAIN) |
				(m == `ACC_SM_SYS_OFS) | (m == `ACC_SM_SYS_GAIN) |
				(m == `ACC_SM_INT_FULL);
		end
	endfunction

	// ****************************************
	// Arithmetic
	// ****************************************
	// offset then gain
	assign diff = $signed({i_raw_sample[23], i_raw_sample}) - $signed({ofs_ff[23], ofs_ff});
	assign prod = diff * $signed({1'b0, gain_ff});
	assign fs_span = $signed({sample_ff[23], sample_ff}) - $signed({ofs_ff[23], ofs_ff});
	assign gain_calc = ({24'h000000, `ACC_FULL_SCALE} << `ACC_GAIN_FRAC) /
		{23'h000000, fs_span};

	always @* begin
		if (fs_span <= 25'sd0)
			gain_new = `ACC_RST_GAIN;
		else if (gain_calc[47:24] != 24'h000000)
			gain_new = 24'hffffff;
		else
			gain_new = gain_calc[23:0];
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (wr_en && idx == `ACC_IDX_MODE && is_cal(i_pwdata[2:0])) begin
					if (i_pwdata[2:0] == `ACC_SM_INT_GAIN || i_pwdata[2:0] == `ACC_SM_SYS_GAIN)
						nxt_state = ST_GAIN;
					else
						nxt_state = ST_OFS;
				end
			end
			ST_OFS: begin
				if (meas_cnt_ff == 8'h00 && i_raw_valid)
					nxt_state = full_ff ? ST_GAIN : ST_DONE;
			end
			ST_GAIN: begin
				if (meas_cnt_ff == 8'h00 && i_raw_valid)
					nxt_state = ST_DONE;
			end
			ST_DONE: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always @(posedge i_mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff    <= ST_IDLE;
			mode_ff     <= `ACC_SM_IDLE;
			full_ff     <= 1'b0;
			sys_ff      <= 1'b0;
			meas_cnt_ff <= 8'h00;
			sample_ff   <= 24'h000000;
			ofs_ff      <= `ACC_RST_OFS;
			gain_ff     <= `ACC_RST_GAIN;
			o_input_buffer_control <= `ACC_RST_BUF;
			o_ain_to_ground    <= 1'b0;
			o_ain_to_fullscale <= 1'b0;
			calc_evt    <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			calc_evt <= 1'b0;
			if (state_ff[0]) begin
				if (nxt_state != ST_IDLE) begin
					mode_ff     <= wr_mode;
					full_ff     <= (wr_mode == `ACC_SM_INT_FULL);
					sys_ff      <= wr_sys;
					meas_cnt_ff <= MEAS_CYC;
					o_ain_to_ground <= (nxt_state == ST_OFS) & ~wr_sys;
					o_ain_to_fullscale <= (nxt_state == ST_GAIN) & ~wr_sys;
				end else if (mode_wr) begin
					mode_ff <= wr_mode;
				end
				if (wr_en) begin
					case (idx)
						`ACC_IDX_OFS_H: ofs_ff[23:16] <= i_pwdata[7:0];
						`ACC_IDX_OFS_M: ofs_ff[15:8]  <= i_pwdata[7:0];
						`ACC_IDX_OFS_L: ofs_ff[7:0]   <= i_pwdata[7:0];
						`ACC_IDX_GAIN_H: gain_ff[23:16] <= i_pwdata[7:0];
						`ACC_IDX_GAIN_M: gain_ff[15:8]  <= i_pwdata[7:0];
						`ACC_IDX_GAIN_L: gain_ff[7:0]   <= i_pwdata[7:0];
						`ACC_IDX_BUF: o_input_buffer_control <= i_pwdata[7:0];
						default: ;
					endcase
				end
			end else if (state_ff == ST_OFS) begin
				if (meas_cnt_ff != 8'h00)
					meas_cnt_ff <= meas_cnt_ff - 8'h01;
				else if (i_raw_valid) begin
					ofs_ff <= i_raw_sample;
					meas_cnt_ff <= MEAS_CYC;
					o_ain_to_ground    <= 1'b0;
					o_ain_to_fullscale <= full_ff;
				end
			end else if (state_ff == ST_GAIN) begin
				if (meas_cnt_ff != 8'h00)
					meas_cnt_ff <= meas_cnt_ff - 8'h01;
				else if (i_raw_valid) begin
					sample_ff <= i_raw_sample;
					o_ain_to_fullscale <= 1'b0;
				end
			end else if (state_ff == ST_DONE) begin
				if (mode_ff == `ACC_SM_INT_GAIN || mode_ff == `ACC_SM_SYS_GAIN ||
					mode_ff == `ACC_SM_INT_FULL)
					gain_ff <= gain_new;
				mode_ff  <= `ACC_SM_IDLE;
				full_ff  <= 1'b0;
				calc_evt <= 1'b1;
			end
		end
	end

	// ****************************************
	// Conversion output
	// ****************************************
	always @(posedge i_mclk or negedge rst_b) begin
		if (!rst_b) begin
			o_corr_sample <= 24'h000000;
			o_corr_valid  <= 1'b0;
			conv_evt      <= 1'b0;
		end else begin
			o_corr_valid <= i_raw_valid & ~busy & (mode_ff == `ACC_SM_CONT);
			conv_evt     <= i_raw_valid & ~busy & (mode_ff == `ACC_SM_CONT);
			if (i_raw_valid & ~busy)
				o_corr_sample <= prod[45:22];
		end
	end

	// ****************************************
	// Status flags
	// ****************************************
	assign sts_set = {conv_evt, 1'b0, calc_evt};
	assign sts_clr = sts_wr ? i_pwdata[2:0] : 3'h0;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_sts
			always @(posedge i_mclk or negedge rst_b) begin
				if (!rst_b)
					sts_ff[gi] <= 1'b0;
				else
					sts_ff[gi] <= sts_set[gi] | (sts_ff[gi] & ~sts_clr[gi]);
			end
		end
	endgenerate

	// ****************************************
	// Mask and interrupt
	// ****************************************
	always @(posedge i_mclk or negedge rst_b) begin
		if (!rst_b) begin
			mask_ff <= 3'h0;
			o_irq   <= 1'b0;
		end else begin
			if (mask_wr)
				mask_ff <= wr_mode;
			o_irq <= |((sts_ff | sts_set) & mask_ff & 3'b101);
		end
	end

	// ****************************************
	// Read data select
	// ****************************************
	always @* begin
		nxt_prdata = 32'h00000000;
		case (idx)
			`ACC_IDX_MODE:   nxt_prdata = {29'h0, mode_ff};
			`ACC_IDX_STATUS: nxt_prdata = {29'h0, sts_ff[2], busy, sts_ff[0]};
			`ACC_IDX_IMASK:  nxt_prdata = {29'h0, mask_ff};
			`ACC_IDX_OFS_H:  nxt_prdata = {24'h0, ofs_ff[23:16]};
			`ACC_IDX_OFS_M:  nxt_prdata = {24'h0, ofs_ff[15:8]};
			`ACC_IDX_OFS_L:  nxt_prdata = {24'h0, ofs_ff[7:0]};
			`ACC_IDX_GAIN_H: nxt_prdata = {24'h0, gain_ff[23:16]};
			`ACC_IDX_GAIN_M: nxt_prdata = {24'h0, gain_ff[15:8]};
			`ACC_IDX_GAIN_L: nxt_prdata = {24'h0, gain_ff[7:0]};
			`ACC_IDX_BUF:    nxt_prdata = {24'h0, o_input_buffer_control};
			`ACC_IDX_RESULT: nxt_prdata = {8'h0, o_corr_sample};
			default:         nxt_prdata = 32'h00000000;
		endcase
	end

	// ****************************************
	// APB slave
	// ****************************************
	always @(posedge i_mclk or negedge rst_b) begin
		if (!rst_b) begin
			o_prdata  <= 32'h00000000;
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready  <= i_psel & ~i_penable;
			o_pslverr <= i_psel & ~i_penable & ~known(idx);
			// Data taken at setup, shown in access
			if (rd_en)
				o_prdata <= nxt_prdata;
		end
	end

endmodule // acc_cal_ctrl

/* File: verif/acc_cal_ctrl_monitor.sv */
// Concurrent checks on the calibration control block ports
// Assumes binding onto acc_cal_ctrl with one clock domain
`timescale 1ns/10ps
`include "acc_defs.vh"
module acc_cal_monitor (
	input wire        i_mclk,
	input wire        i_rst_b,
	input wire        i_psel,
	input wire        i_penable,
	input wire        i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	input wire        i_raw_valid,
	input wire        o_pready,
	input wire        o_pslverr,
	input wire        o_ain_to_ground,
	input wire        o_ain_to_fullscale,
	input wire        o_corr_valid,
	input wire [7:0]  o_input_buffer_control,
	input wire        o_irq
);
	// ****************
	// Properties
	// ****************
	wire wr_acc = i_psel & i_penable & o_pready & i_pwrite;
	wire idle_an = !o_ain_to_ground && !o_ain_to_fullscale;
	wire mwr = wr_acc && (i_paddr[9:2] == `ACC_IDX_MODE) && idle_an;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	a_ready_single: assert property (o_pready |=> !o_pready)
		else $error("ready high two cycles");
	a_err_ready: assert property (o_pslverr |-> o_pready)
		else $error("error without ready");
	a_ready_setup: assert property ($rose(o_pready) |-> $past(i_psel && !i_penable))
		else $error("ready without setup");
	a_ground_start: assert property (mwr && i_pwdata[2:0] == 3'h4 |=> o_ain_to_ground)
		else $error("offset cal did not ground inputs");
	a_gain_start: assert property (mwr && i_pwdata[2:0] == 3'h5 |=> o_ain_to_fullscale)
		else $error("gain cal did not apply full scale");
	a_inputs_exclusive: assert property (!(o_ain_to_ground && o_ain_to_fullscale))
		else $error("ground and full scale together");
	a_ground_end: assert property ($fell(o_ain_to_ground) |-> $past(i_raw_valid))
		else $error("ground released without sample");
	a_corr_idle: assert property (o_corr_valid |-> idle_an)
		else $error("corrected sample during calibration");
	a_buf_stable: assert property (!(wr_acc && i_paddr[9:2] == `ACC_IDX_BUF)
		|=> $stable(o_input_buffer_control))
		else $error("buffer control changed without write");
	c_ground: cover property ($rose(o_ain_to_ground));
	c_fullscale: cover property ($rose(o_ain_to_fullscale));
	c_irq: cover property ($rose(o_irq));
endmodule // acc_cal_monitor
bind acc_cal_ctrl acc_cal_monitor u_mon (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_psel(i_psel),
	.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
	.i_raw_valid(i_raw_valid), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.o_ain_to_ground(o_ain_to_ground), .o_ain_to_fullscale(o_ain_to_fullscale),
	.o_corr_valid(o_corr_valid), .o_input_buffer_control(o_input_buffer_control), .o_irq(o_irq));

/* File: verif/test_adc_calibration_control.sv */
// Self-checking bench for the calibration control block
// Assumes acc_cal_ctrl on a 100 MHz clock, bench as APB master
`timescale 1ns/10ps
`include "acc_defs.vh"
module test_adc_calibration_control;
	logic i_mclk = 0, i_rst_b = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, i_raw_valid = 0;
	logic [11:0] i_paddr = 0;
	logic [31:0] i_pwdata = 0, o_prdata;
	logic [23:0] i_raw_sample = 0, o_corr_sample, a, b, x;
	logic o_pready, o_pslverr, o_ain_to_ground, o_ain_to_fullscale, o_corr_valid, o_irq;
	logic [7:0] o_input_buffer_control, bufv;
	logic [32:0] exp_q[$];
	logic [7:0] ridx[8] = '{`ACC_IDX_BUF, `ACC_IDX_OFS_L, `ACC_IDX_OFS_M, `ACC_IDX_OFS_H,
		`ACC_IDX_GAIN_L, `ACC_IDX_GAIN_M, `ACC_IDX_GAIN_H, 8'h10};
	logic [32:0] rval[8] = '{0, 0, 0, 0, 0, 0, 33'h40, 33'h100000000};
	int n_errors = 0, total_checks = 0, cyc = 0, k, n;
	acc_cal_ctrl uut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.i_raw_sample(i_raw_sample), .i_raw_valid(i_raw_valid),
		.o_ain_to_ground(o_ain_to_ground), .o_ain_to_fullscale(o_ain_to_fullscale),
		.o_corr_sample(o_corr_sample), .o_corr_valid(o_corr_valid),
		.o_input_buffer_control(o_input_buffer_control), .o_irq(o_irq));
	always #5 i_mclk = ~i_mclk;
	// ****************
	// Checking and bus tasks
	// ****************
	task chk(input logic [32:0] seen, input logic [32:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		$display("checks=%0d errors=%0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			wrap_up;
		end
		if (i_psel && i_penable && o_pready === 1'b1 && !i_pwrite)
			chk({o_pslverr, o_prdata}, exp_q.pop_front());
	end
	task apb(input logic w, input logic [7:0] idx, input logic [32:0] d);
		i_psel <= 1;
		i_pwrite <= w;
		i_paddr <= {2'b00, idx, 2'b00};
		i_pwdata <= w ? d[31:0] : $urandom;
		if (!w) exp_q.push_back(d);
		@(posedge i_mclk);
		i_penable <= 1;
		n = 0;
		do @(posedge i_mclk); while (o_pready !== 1'b1 && ++n < 50);
		i_psel <= 0;
		i_penable <= 0;
		@(posedge i_mclk);
	endtask
	task pulse(input logic [23:0] s);
		i_raw_valid <= 1;
		i_raw_sample <= s;
		@(posedge i_mclk);
		i_raw_valid <= 0;
		i_raw_sample <= ~s;
		repeat (25) @(posedge i_mclk);
	endtask
	task rd24(input logic [7:0] i, input logic [23:0] v);
		for (int j = 0; j < 3; j++) apb(0, i + j, v[8*j+:8]);
	endtask
	function logic [23:0] gexp(input logic [23:0] span);
		logic [47:0] q;
		q = (48'h3fffff << 22) / span;
		return q > 48'hffffff ? 24'hffffff : q[23:0];
	endfunction
	task cal(input logic [2:0] m, input logic [23:0] s1, input logic [23:0] s2);
		apb(1, `ACC_IDX_MODE, m);
		apb(0, `ACC_IDX_STATUS, 33'h2);
		chk(o_ain_to_ground, m == 4 || m == 3);
		chk(o_ain_to_fullscale, m == 5);
		apb(1, `ACC_IDX_BUF, ~bufv);
		repeat (20) @(posedge i_mclk);
		pulse(s1);
		if (m == 3) chk(o_ain_to_fullscale, 1);
		if (m == 3) pulse(s2);
		chk(o_irq, 1);
		apb(0, `ACC_IDX_MODE, 0);
		apb(0, `ACC_IDX_STATUS, 1);
		apb(0, `ACC_IDX_BUF, bufv);
		apb(1, `ACC_IDX_STATUS, 1);
		apb(0, `ACC_IDX_STATUS, 0);
		chk(o_irq, 0);
	endtask
	// ****************
	// Main sequence
	// ****************
	initial begin
		k = $urandom(32'h2618f891);
		repeat (20) @(posedge i_mclk);
		i_rst_b <= 1;
		repeat (3) @(posedge i_mclk);
		for (k = 0; k < 8; k++) apb(0, ridx[k], rval[k]);
		for (k = 0; k < 7; k++) begin
			a = $urandom;
			apb(1, ridx[k], {1'b0, a, a[7:0]});
			apb(0, ridx[k], a[7:0]);
		end
		bufv = a[7:0] ^ 8'h5a;
		apb(1, `ACC_IDX_BUF, bufv);
		chk(o_input_buffer_control, bufv);
		apb(1, `ACC_IDX_IMASK, 1);
		for (k = 0; k < 3; k++) begin
			a = $urandom_range(0, 255);
			b = a + $urandom_range(24'h200000, 24'h3fffff);
			if (k == 2) cal(3, a, b);
			else begin
				cal(4 + 2 * k, a, 0);
				cal(5 + 2 * k, b, 0);
			end
			rd24(`ACC_IDX_OFS_L, a);
			rd24(`ACC_IDX_GAIN_L, gexp(b - a));
		end
		apb(1, `ACC_IDX_MODE, `ACC_SM_CONT);
		x = a + $urandom_range(1, 16'hffff);
		pulse(x);
		n = 0;
		i_raw_valid <= 1;
		i_raw_sample <= x;
		while (o_corr_valid !== 1'b1 && n++ < 50) @(posedge i_mclk);
		i_raw_valid <= 0;
		chk(o_corr_sample, 24'((48'(x - a) * gexp(b - a)) >> 22));
		apb(1, `ACC_IDX_MODE, `ACC_SM_IDLE);
		wrap_up;
	end
endmodule // test_adc_calibration_control
